// >>> hdl/eeprom_device.sv
// Serial EEPROM device end: command engine, array, protection and status.
`include "eeprom_link_regs.svh"

module eeprom_device
    import eeprom_link_pkg::*;
(
    // System
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Link
    eeprom_link_if.device   link,
    // Observation
    output logic            prog_busy,
    output logic [7:0]      status_byte
);

    dev_state_type state;
    logic [1:0]  sck_s, cs_s, si_s, wp_s;
    logic        sck_q, cs_q;
    logic [2:0]  bit_cnt;
    logic [6:0]  rx_sh;
    logic [7:0]  tx_sh, pend_status;
    logic [15:0] addr, prog_cnt;
    logic        addr_hi_done, is_read, got_byte, prog_status;
    logic        wel, protect_arm_bit, block_protect_lo, block_protect_hi;
    logic [7:0]  mem [0:`MEM_DEPTH-1];
    logic [7:0]  page_data [0:`PAGE_SIZE-1];
    logic [`PAGE_SIZE-1:0] page_vld;
    logic        sck_rise, sck_fall, cs_fall, cs_rise, selected, byte_done;
    logic        hw_prot, prog_go, prog_done;
    logic [7:0]  rx_byte, opcode, live_status;

    function automatic logic is_protected(input logic [15:0] a,
                                          input logic hi, input logic lo);
        case ({hi, lo})
            2'b01:   is_protected = (a >= `QUARTER_BASE);
            2'b10:   is_protected = (a >= `HALF_BASE);
            2'b11:   is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction : is_protected

    // Every pin passes two flops before any logic looks at it.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sck_s <= 2'b00;
            cs_s  <= 2'b11;
            si_s  <= 2'b00;
            wp_s  <= 2'b11;
            sck_q <= 1'b0;
            cs_q  <= 1'b1;
        end else begin
            sck_s <= {sck_s[0], link.sck};
            cs_s  <= {cs_s[0], link.cs_n};
            si_s  <= {si_s[0], link.si};
            wp_s  <= {wp_s[0], link.wp_n};
            sck_q <= sck_s[1];
            cs_q  <= cs_s[1];
        end
    end

    assign selected  = ~cs_s[1];
    assign cs_fall   = ~cs_s[1] & cs_q;
    assign cs_rise   = cs_s[1] & ~cs_q;
    assign sck_rise  = sck_s[1] & ~sck_q & selected;
    assign sck_fall  = ~sck_s[1] & sck_q & selected;
    assign byte_done = sck_rise & (bit_cnt == 3'd7);
    assign rx_byte   = {rx_sh, si_s[1]};
    assign opcode    = rx_byte & `OPCODE_MASK;
    assign hw_prot   = protect_arm_bit & ~wp_s[1];
    assign live_status = prog_busy ? `ST_BUSY_VALUE :
        {protect_arm_bit, 3'b000, block_protect_hi, block_protect_lo,
         wel, 1'b0};

    assign prog_go = cs_rise & ~prog_busy & got_byte & (bit_cnt == 3'd0)
        & ((state == DEV_WR_DATA) | ((state == DEV_ST_WR) & ~hw_prot));
    assign prog_done = prog_busy & (prog_cnt == 16'h0000);

    // Command, address and data framing on the serial link.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state        <= DEV_IDLE;
            bit_cnt      <= 3'd0;
            rx_sh        <= 7'd0;
            addr         <= 16'h0000;
            addr_hi_done <= 1'b0;
            is_read      <= 1'b0;
            got_byte     <= 1'b0;
        end else if (cs_rise) begin
            state <= DEV_IDLE;
        end else if (cs_fall) begin
            state    <= DEV_CMD;
            bit_cnt  <= 3'd0;
            got_byte <= 1'b0;
        end else if (sck_rise && state != DEV_IDLE) begin
            bit_cnt <= bit_cnt + 3'd1;
            rx_sh   <= rx_byte[6:0];
            if (byte_done) begin
                case (state)
                    DEV_CMD: begin
                        addr_hi_done <= 1'b0;
                        is_read      <= (opcode == `OP_ARRAY_READ);
                        if (prog_busy && opcode != `OP_STATUS_READ)
                            state <= DEV_IGNORE;
                        else if (opcode == `OP_ARRAY_READ)
                            state <= DEV_ADDR;
                        else if (opcode == `OP_ARRAY_WRITE)
                            state <= wel ? DEV_ADDR : DEV_IGNORE;
                        else if (opcode == `OP_STATUS_WRITE)
                            state <= wel ? DEV_ST_WR : DEV_IGNORE;
                        else if (opcode == `OP_STATUS_READ)
                            state <= DEV_ST_RD;
                        else
                            state <= DEV_IGNORE;
                    end
                    DEV_ADDR: begin
                        if (!addr_hi_done) begin
                            addr[15:8]   <= rx_byte;
                            addr_hi_done <= 1'b1;
                        end else begin
                            addr[7:0] <= rx_byte;
                            state     <= is_read ? DEV_RD_DATA : DEV_WR_DATA;
                        end
                    end
                    DEV_RD_DATA: addr <= addr + 16'h0001;
                    DEV_WR_DATA: begin
                        addr[`PAGE_BITS-1:0] <= addr[`PAGE_BITS-1:0] + 7'd1;
                        got_byte <= 1'b1;
                    end
                    DEV_ST_WR: got_byte <= 1'b1;
                    default:   state <= state;
                endcase
            end
        end
    end

    // Outgoing byte: loaded after a rising edge, shifted after a falling one.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tx_sh       <= 8'h00;
            link.so_out <= 1'b0;
        end else if (byte_done && state == DEV_ADDR && addr_hi_done) begin
            tx_sh <= mem[{addr[15:8], rx_byte}];
        end else if (byte_done && state == DEV_RD_DATA) begin
            tx_sh <= mem[addr + 16'h0001];
        end else if (byte_done && state inside {DEV_CMD, DEV_ST_RD}) begin
            tx_sh <= live_status;
        end else if (sck_fall) begin
            link.so_out <= tx_sh[7];
            tx_sh       <= {tx_sh[6:0], 1'b0};
        end
    end

    assign link.so_oe_n = ~(selected &
        ((state == DEV_RD_DATA) | (state == DEV_ST_RD)));

    // Self-timed programming cycle.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prog_busy   <= 1'b0;
            prog_cnt    <= 16'h0000;
            prog_status <= 1'b0;
        end else if (prog_go) begin
            prog_busy   <= 1'b1;
            prog_cnt    <= 16'(`PROG_CYCLES - 1);
            prog_status <= (state == DEV_ST_WR);
        end else if (prog_done) begin
            prog_busy <= 1'b0;
        end else if (prog_busy) begin
            prog_cnt <= prog_cnt - 16'h0001;
        end
    end

    // Write latch and nonvolatile status bits.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wel              <= 1'b0;
            protect_arm_bit  <= 1'b0;
            block_protect_lo <= 1'b0;
            block_protect_hi <= 1'b0;
            pend_status      <= 8'h00;
        end else begin
            if (byte_done && state == DEV_CMD && !prog_busy) begin
                if (opcode == `OP_SET_WRITE)
                    wel <= 1'b1;
                else if (opcode == `OP_CLR_WRITE)
                    wel <= 1'b0;
            end
            if (byte_done && state == DEV_ST_WR)
                pend_status <= rx_byte;
            if (prog_done) begin
                wel <= 1'b0;
                if (prog_status) begin
                    protect_arm_bit  <= pend_status[`ST_ARM_BIT];
                    block_protect_lo <= pend_status[`ST_BP_LO_BIT];
                    block_protect_hi <= pend_status[`ST_BP_HI_BIT];
                end
            end
        end
    end

    // Page buffer, so the array only changes once select has risen.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            page_vld <= '0;
        end else if (byte_done && state == DEV_ADDR && addr_hi_done) begin
            page_vld <= '0;
        end else if (byte_done && state == DEV_WR_DATA) begin
            page_data[addr[`PAGE_BITS-1:0]] <= rx_byte;
            page_vld[addr[`PAGE_BITS-1:0]]  <= 1'b1;
        end
    end

    // The array is uninitialised storage; its content at power-up is unknown.
    always_ff @(posedge clock) begin
        if (prog_done && !prog_status) begin
            for (int i = 0; i < `PAGE_SIZE; i++) begin
                if (page_vld[i] && !is_protected({addr[15:7], 7'(i)},
                        block_protect_hi, block_protect_lo))
                    mem[{addr[15:7], 7'(i)}] <= page_data[i];
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            status_byte <= 8'h00;
        else
            status_byte <= live_status;
    end

endmodule : eeprom_device

// >>> hdl/eeprom_link_regs.svh
// Opcodes, status layout, geometry and timing of the serial EEPROM link.
`ifndef EEPROM_LINK_REGS_SVH
`define EEPROM_LINK_REGS_SVH

// Opcodes after masking the don't-care bit three.
`define OPCODE_MASK      8'hF7
`define OP_SET_WRITE     8'h06
`define OP_CLR_WRITE     8'h04
`define OP_STATUS_READ   8'h05
`define OP_STATUS_WRITE  8'h01
`define OP_ARRAY_READ    8'h03
`define OP_ARRAY_WRITE   8'h02

// Status byte fields.
`define ST_BUSY_BIT      0
`define ST_WEL_BIT       1
`define ST_BP_LO_BIT     2
`define ST_BP_HI_BIT     3
`define ST_ARM_BIT       7
`define ST_BUSY_VALUE    8'hFF

// Array geometry.
`define MEM_DEPTH        65536
`define PAGE_SIZE        128
`define PAGE_BITS        7
`define QUARTER_BASE     16'hC000
`define HALF_BASE        16'h8000

// Self-timed programming and master serial clock timing.
`define CLOCK_NS         8
`define PROG_TIME_NS     1000
`define PROG_CYCLES      ((`PROG_TIME_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define SCK_HALF_NS      96
`define SCK_HALF_CYCLES  (`SCK_HALF_NS / `CLOCK_NS)

// Master register indices.
`define REG_TX           4'h0
`define REG_RX           4'h1
`define REG_CTRL         4'h2
`define REG_STATUS       4'h3

`endif

// >>> hdl/eeprom_link_pkg.sv
// Types shared by both ends of the serial EEPROM link.
package eeprom_link_pkg;

    typedef enum logic [7:0] {
        DEV_IDLE    = 8'b0000_0001,
        DEV_CMD     = 8'b0000_0010,
        DEV_ADDR    = 8'b0000_0100,
        DEV_RD_DATA = 8'b0000_1000,
        DEV_WR_DATA = 8'b0001_0000,
        DEV_ST_RD   = 8'b0010_0000,
        DEV_ST_WR   = 8'b0100_0000,
        DEV_IGNORE  = 8'b1000_0000
    } dev_state_type;

    typedef enum logic [2:0] {
        MST_IDLE = 3'b001,
        MST_LOW  = 3'b010,
        MST_HIGH = 3'b100
    } mst_state_type;

endpackage : eeprom_link_pkg

// >>> hdl/eeprom_link_if.sv
// Serial link wires between the EEPROM master and the EEPROM device.
interface eeprom_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic so_out;
    logic so_oe_n;
    logic so_line;

    // A pull-up holds the serial output high while nobody drives it.
    assign so_line = so_oe_n ? 1'b1 : so_out;

    modport device (
        input  cs_n,
        input  sck,
        input  si,
        input  wp_n,
        output so_out,
        output so_oe_n
    );

    modport master (
        output cs_n,
        output sck,
        output si,
        output wp_n,
        input  so_line
    );
endinterface : eeprom_link_if

// >>> hdl/eeprom_master.sv
// Serial EEPROM master end: byte shifter driven from a small register port.
`include "eeprom_link_regs.svh"

module eeprom_master
    import eeprom_link_pkg::*;
(
    // System
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Link
    eeprom_link_if.master   link
);

    mst_state_type state;
    logic [1:0] so_s;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic [2:0] bit_cnt;
    logic [7:0] half_cnt;
    logic       select;
    logic       wp_level;
    logic       start;

    // A byte written while the shifter is busy is dropped.
    assign start = reg_wr & (reg_addr == `REG_TX) & (state == MST_IDLE);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            so_s <= 2'b11;
        else
            so_s <= {so_s[0], link.so_line};
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            select   <= 1'b0;
            wp_level <= 1'b1;
        end else if (reg_wr && reg_addr == `REG_CTRL) begin
            select   <= reg_wdata[0];
            wp_level <= reg_wdata[1];
        end
    end

    assign link.cs_n = ~select;
    assign link.wp_n = wp_level;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= MST_IDLE;
            tx_sh    <= 8'h00;
            rx_sh    <= 8'h00;
            rx_data  <= 8'h00;
            bit_cnt  <= 3'd0;
            half_cnt <= 8'd0;
            link.sck <= 1'b0;
            link.si  <= 1'b0;
        end else begin
            case (state)
                MST_IDLE: begin
                    if (start) begin
                        tx_sh    <= reg_wdata;
                        link.si  <= reg_wdata[7];
                        bit_cnt  <= 3'd0;
                        half_cnt <= 8'(`SCK_HALF_CYCLES - 1);
                        state    <= MST_LOW;
                    end
                end
                MST_LOW: begin
                    if (half_cnt == 8'd0) begin
                        link.sck <= 1'b1;
                        rx_sh    <= {rx_sh[6:0], so_s[1]};
                        half_cnt <= 8'(`SCK_HALF_CYCLES - 1);
                        state    <= MST_HIGH;
                    end else begin
                        half_cnt <= half_cnt - 8'd1;
                    end
                end
                MST_HIGH: begin
                    if (half_cnt == 8'd0) begin
                        link.sck <= 1'b0;
                        if (bit_cnt == 3'd7) begin
                            rx_data <= rx_sh;
                            state   <= MST_IDLE;
                        end else begin
                            bit_cnt  <= bit_cnt + 3'd1;
                            tx_sh    <= {tx_sh[6:0], 1'b0};
                            link.si  <= tx_sh[6];
                            half_cnt <= 8'(`SCK_HALF_CYCLES - 1);
                            state    <= MST_LOW;
                        end
                    end else begin
                        half_cnt <= half_cnt - 8'd1;
                    end
                end
                default: begin
                    state <= MST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_RX:     reg_rdata <= rx_data;
                `REG_CTRL:   reg_rdata <= {6'd0, wp_level, select};
                `REG_STATUS: reg_rdata <= {7'd0, state != MST_IDLE};
                default:     reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : eeprom_master

// >>> sim/eeprom_link_assertions.sv
// Concurrent checks on the link between the EEPROM master and device.
`include "eeprom_link_regs.svh"

module eeprom_link_assertions (
    // System
    input wire logic       clock,
    input wire logic       sys_rst,
    // Link
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic       si,
    input wire logic       wp_n,
    input wire logic       so_out,
    input wire logic       so_oe_n,
    input wire logic       so_line,
    // Device observation
    input wire logic       prog_busy,
    input wire logic [7:0] status_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG_N = `PROG_CYCLES;
    logic [8:0]    busy_cnt;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // A counter, since the programming time is far beyond a repetition.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            busy_cnt <= 9'h000;
        end else if (prog_busy) begin
            busy_cnt <= busy_cnt + 9'h001;
        end else begin
            busy_cnt <= 9'h000;
        end
    end

    property p_oe_off;
        cs_n [*5] |-> so_oe_n;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("serial output driven while deselected");

    property p_busy_start;
        $rose(prog_busy) |-> cs_n && $past(cs_n, 2);
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("programming started while selected");

    property p_busy_len;
        $fell(prog_busy) |-> busy_cnt == PROG_N;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("programming time wrong");

    property p_sel_sck;
        $rose(cs_n) || $fell(cs_n) |-> !sck;
    endproperty
    a_sel_sck: assert property (p_sel_sck)
        else $error("select moved while serial clock high");

    property p_so_chg;
        !cs_n && $changed(so_out) |-> !sck;
    endproperty
    a_so_chg: assert property (p_so_chg)
        else $error("serial output changed while clock high");

    property p_st_idle;
        !prog_busy && !$past(prog_busy) && !$past(prog_busy, 2)
            |-> status_byte[6:4] == 3'b000 && !status_byte[0];
    endproperty
    a_st_idle: assert property (p_st_idle)
        else $error("idle status shows busy or stray bits");

    property p_wel_clr;
        $fell(prog_busy) |-> ##[1:3] !status_byte[1];
    endproperty
    a_wel_clr: assert property (p_wel_clr)
        else $error("write latch kept after programming");

    property p_arm_keep;
        $fell(status_byte[7]) |-> wp_n;
    endproperty
    a_arm_keep: assert property (p_arm_keep)
        else $error("arming bit cleared while pin low");

    c_prog: cover property ($rose(prog_busy));
    c_read: cover property (!so_oe_n && !so_line);
    c_disarm: cover property ($fell(status_byte[7]));
endmodule : eeprom_link_assertions

// >>> sim/spi_eeprom_rw_protect_tb.sv
// Self-checking bench for the EEPROM master and device pair.
`include "eeprom_link_regs.svh"

module spi_eeprom_rw_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] status_byte;
    logic       prog_busy;
    logic [7:0] wire_sr;
    logic [7:0] rxq[$];
    logic [7:0] mem[int];
    logic       wel = 1'b0;
    logic       arm = 1'b0;
    logic       wp = 1'b1;
    logic [1:0] bp = 2'b00;
    int         errors = 0;
    int         total_checks = 0;
    int         seed = 32'h1a6e;

    eeprom_link_if link ();
    eeprom_master u_eeprom_master (.clock, .sys_rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .link(link));
    eeprom_device u_eeprom_device (.clock, .sys_rst, .link(link),
        .prog_busy, .status_byte);
    eeprom_link_assertions u_eeprom_link_assertions (.clock, .sys_rst,
        .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .wp_n(link.wp_n),
        .so_out(link.so_out), .so_oe_n(link.so_oe_n),
        .so_line(link.so_line), .prog_busy, .status_byte);

    always #4 clock = ~clock;

    // The wire itself is watched, so a reversed shifter cannot hide.
    always @(posedge link.sck) wire_sr <= {wire_sr[6:0], link.si};

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic timeout;
        errors++;
        close_out();
    endtask : timeout

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic bus(input logic [3:0] a, input logic [7:0] d,
                       input logic w, output logic [7:0] q);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : bus

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        logic [7:0] s;
        bus(4'h0, tx, 1'b1, s);
        for (int i = 0; i <= 400; i++) begin
            if (i == 400) timeout();
            bus(4'h3, 8'h00, 1'b0, s);
            if (s[0] === 1'b0) break;
        end
        check(wire_sr, tx);
        bus(4'h1, 8'h00, 1'b0, rx);
    endtask : xfer

    task automatic sel(input logic on);
        logic [7:0] s;
        bus(4'h2, {6'h00, wp, on}, 1'b1, s);
    endtask : sel

    // A gap before select falls lets the device see a fresh frame.
    task automatic frame(input logic [7:0] tx[$]);
        logic [7:0] r;
        rxq = {};
        repeat (8) @(posedge clock);
        sel(1'b1);
        foreach (tx[i]) begin
            xfer(tx[i], r);
            rxq.push_back(r);
        end
        sel(1'b0);
    endtask : frame

    task automatic wait_prog(input logic want);
        int n;
        n = 0;
        for (int i = 0; i <= 40 && want; i++) begin
            @(posedge clock);
            #1;
            if (prog_busy === 1'b1) break;
            if (i == 40) timeout();
        end
        if (!want) begin
            repeat (8) @(posedge clock);
            #1;
            check(8'(prog_busy), 8'h00);
        end
        while (prog_busy === 1'b1) begin
            n++;
            if (n == 3) check(status_byte, 8'hFF);
            if (n > 300) timeout();
            @(posedge clock);
            #1;
        end
        if (want) check(8'(n), 8'(`PROG_CYCLES));
        if (want) wel = 1'b0;
        repeat (160) @(posedge clock);
    endtask : wait_prog

    function automatic logic prot(input logic [15:0] a);
        return bp == 2'd3 || (bp == 2'd2 && a[15]) ||
            (bp == 2'd1 && a[15:14] == 2'b11);
    endfunction : prot

    task automatic cmd(input logic [7:0] op);
        frame({op});
        if (op == 8'h06) wel = 1'b1;
        if (op == 8'h04) wel = 1'b0;
    endtask : cmd

    task automatic st_rd;
        frame({8'h05, 8'($random(seed))});
        check(rxq[1], {arm, 3'b000, bp, wel, 1'b0});
    endtask : st_rd

    task automatic st_wr(input logic [7:0] v);
        logic ok;
        ok = wel && !(arm && !wp);
        frame({8'h01, v});
        wait_prog(ok);
        if (ok) {arm, bp} = {v[7], v[3:2]};
        cmd(8'h04);
    endtask : st_wr

    task automatic mwr(input logic [15:0] ad, input int n);
        logic [7:0] q[$];
        logic [7:0] d;
        logic [15:0] a;
        logic want;
        q = {8'h02, ad[15:8], ad[7:0]};
        want = wel;
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            a = {ad[15:7], 7'(ad[6:0] + i)};
            q.push_back(d);
            if (wel && !prot(a)) mem[a] = d;
        end
        frame(q);
        wait_prog(want);
        if (wel) cmd(8'h04);
    endtask : mwr

    task automatic mrd(input logic [15:0] ad, input int n);
        logic [7:0] q[$];
        logic [15:0] a;
        q = {8'h03, ad[15:8], ad[7:0]};
        for (int i = 0; i < n; i++) q.push_back(8'($random(seed)));
        frame(q);
        for (int i = 0; i < n; i++) begin
            a = ad + 16'(i);
            if (mem.exists(a)) check(rxq[3 + i], mem[a]);
        end
    endtask : mrd

    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        st_rd();
        cmd(8'h06);
        st_rd();
        mwr(16'hFFFF, 1);
        st_rd();
        cmd(8'h06);
        mwr(16'h0000, 1);
        mwr(16'h0000, 1);
        mrd(16'hFFFF, 2);
        cmd(8'h06);
        mwr(16'h12FE, 130);
        mrd(16'h12FE, 2);
        mrd(16'h1280, 2);
        for (int lv = 0; lv < 4; lv++) begin
            cmd(8'h06);
            st_wr({4'h0, 2'(lv), 2'b00});
            st_rd();
            for (int k = 0; k < 3; k++) begin
                logic [15:0] pa;
                pa = (k == 0) ? 16'h0100 : (k == 1) ? 16'h8100 : 16'hC100;
                cmd(8'h06);
                mwr(pa, 1);
                mrd(pa, 1);
            end
        end
        cmd(8'h06);
        st_wr(8'h80);
        wp = 1'b0;
        cmd(8'h06);
        st_wr(8'h00);
        st_rd();
        wp = 1'b1;
        cmd(8'h06);
        st_wr(8'h00);
        st_rd();
        close_out();
    end
endmodule : spi_eeprom_rw_protect_tb
